//--- logic/pordr_pkg.sv
// Constants for the power-on / power-down reset sequencer.
// Assumes one system clock that the sequencer itself gates during reset.
// How it works
// R1: Power-on detector asserts internal reset regardless of program state.
// R2: Reset asserts without any clock edge, so a stopped oscillator still resets.
// R3: Oscillator stays stopped while either reset source is active.
// R4: On power-on release, timer counts oscillator pulses to a fixed terminal count.
// R5: Normal operation and execution start only after the stability count ends.
// R6: Power-down detection acts only while software holds the enable flag set.
// R7: Enabled low-voltage detection asserts reset to all other units.
// R8: Power-down reset holds until the detector reports recovery or power dies.
// R9: After power-down recovery, stability wait runs, then execution restarts.
// R10: Recovery from 0 V lets the power-on path control the sequence.
// R11: Stability wait is 256 times 256 system clock pulses.
// R12: Each reset sequence ends with the program counter at address zero.
// R13: Detectors are asynchronous; reset asserts async, releases synchronous to clock.
package pordr_pkg;
	localparam int unsigned PORDR_WAIT_CYCLES = 256 * 256;
	localparam int unsigned PORDR_CNT_W = 17;
	localparam logic [PORDR_CNT_W-1:0] PORDR_CNT_RST = 17'h00000;
	localparam int unsigned PORDR_PC_W = 10;
	localparam logic [PORDR_PC_W-1:0] PORDR_START_ADDR = 10'h000;
	localparam logic PORDR_EN_RST = 1'b0;
	typedef enum logic [1:0] {
		PORDR_HOLD,
		PORDR_WAIT,
		PORDR_RUN
	} pordr_state_e;
endpackage

//--- logic/pordr_rst_sync.sv
// Release synchroniser for the already combined reset request.
// Assumes core_clk_i may be stopped while any reset source is active.
`timescale 1ns/10ps
module pordr_rst_sync
	import pordr_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic arst_req_i,
	output logic srst_n_o
);
	logic meta_r;
	logic sync_r;
	// R13 async assert, sync release
	always_ff @(posedge core_clk_i or posedge arst_req_i) begin
		if (arst_req_i) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end else begin
			meta_r <= 1'b1;
			sync_r <= meta_r;
		end
	end
	assign srst_n_o = sync_r;
endmodule

//--- logic/pordr_seq.sv
// Power-on / power-down reset sequencer top.
// Assumes detector inputs come from analog comparators, asynchronous to the clock.
`timescale 1ns/10ps
module pordr_seq
	import pordr_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic por_detect_i,
	input wire logic low_voltage_i,
	input wire logic low_voltage_reset_enable_flag_i,
	input wire logic low_voltage_reset_enable_flag_wr_i,
	output logic osc_enable_o,
	output logic unit_reset_n_o,
	output logic run_o,
	output logic [PORDR_PC_W-1:0] start_pc_o,
	output logic low_voltage_reset_enable_flag_o
);
	logic en_r;
	logic en_nxt;
	logic arst_req;
	logic srst_n;
	pordr_state_e state_r;
	pordr_state_e state_nxt;
	logic [PORDR_CNT_W-1:0] cnt_r;
	logic [PORDR_CNT_W-1:0] cnt_nxt;

	// R6 flag held by software; cleared by power-on
	always_comb begin
		en_nxt = en_r;
		if (low_voltage_reset_enable_flag_wr_i) begin
			en_nxt = low_voltage_reset_enable_flag_i;
		end
	end
	// Flag survives a power-down reset so detection stays armed
	always_ff @(posedge core_clk_i or posedge por_detect_i) begin
		if (por_detect_i) begin
			en_r <= PORDR_EN_RST;
		end else if (!rstn_i) begin
			en_r <= PORDR_EN_RST;
		end else begin
			en_r <= en_nxt;
		end
	end

	// R1 R7 R10 both sources OR'd, power-on wins by clearing enable
	assign arst_req = por_detect_i | (low_voltage_i & en_r);

	pordr_rst_sync u_sync (
		.core_clk_i(core_clk_i),
		.arst_req_i(arst_req),
		.srst_n_o(srst_n)
	);

	// R4 R9 R11 stability wait counter
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		unique case (state_r)
			PORDR_HOLD: begin
				state_nxt = PORDR_WAIT;
				cnt_nxt = PORDR_CNT_RST;
			end
			PORDR_WAIT: begin
				cnt_nxt = cnt_r + 17'h00001;
				if (cnt_r == PORDR_CNT_W'(PORDR_WAIT_CYCLES - 1)) begin
					state_nxt = PORDR_RUN;
				end
			end
			PORDR_RUN: begin
				state_nxt = PORDR_RUN;
			end
		endcase
	end
	// R2 R8 sequencer held while any reset request stands
	always_ff @(posedge core_clk_i or posedge arst_req) begin
		if (arst_req) begin
			state_r <= PORDR_HOLD;
			cnt_r <= PORDR_CNT_RST;
		end else if (!srst_n || !rstn_i) begin
			state_r <= PORDR_HOLD;
			cnt_r <= PORDR_CNT_RST;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// R3 oscillator stopped during reset
	assign osc_enable_o = ~arst_req;
	// R5 units leave reset only after the wait
	assign unit_reset_n_o = (state_r == PORDR_RUN);
	assign run_o = (state_r == PORDR_RUN);
	// R12 restart address
	assign start_pc_o = PORDR_START_ADDR;
	assign low_voltage_reset_enable_flag_o = en_r;

	chk_osc_stop: assert property (@(posedge core_clk_i) // R3
		arst_req |-> !osc_enable_o) else $error("oscillator runs in reset");
	chk_wait_len: assert property (@(posedge core_clk_i) disable iff (arst_req || !rstn_i) // R11
		(state_r == PORDR_WAIT && cnt_r == 17'h00000) |-> !run_o [*8])
		else $error("wait too short");
	chk_run_end: assert property (@(posedge core_clk_i) disable iff (arst_req || !rstn_i) // R4
		(state_r == PORDR_WAIT && cnt_r == PORDR_CNT_W'(PORDR_WAIT_CYCLES - 1)) |=> run_o)
		else $error("wait did not end");
	chk_run_gate: assert property (@(posedge core_clk_i) // R5
		run_o |-> $past(state_r) != PORDR_HOLD) else $error("run without wait");
	chk_lv_reset: assert property (@(posedge core_clk_i) // R7
		(low_voltage_i && en_r) |-> !osc_enable_o) else $error("low voltage ignored");
	chk_lv_masked: assert property (@(posedge core_clk_i) // R6
		(!por_detect_i && !en_r) |-> !arst_req) else $error("disabled detector reset");
	chk_por: assert property (@(posedge core_clk_i) // R1
		por_detect_i |-> !unit_reset_n_o) else $error("power-on not reset");
	chk_start_pc: assert property (@(posedge core_clk_i) // R12
		$rose(run_o) |-> start_pc_o == PORDR_START_ADDR) else $error("bad start address");

	// Checks on the detector-driven reset path.
	// Detector inputs are asynchronous to the clock. These checks sample them at
	// clock edges only, so a glitch between two edges is not seen here.
	chk_lv_hold: assert property (@(posedge core_clk_i) // R8
		(low_voltage_i && en_r) |-> !run_o)
		else $error("run during power-down reset");

	chk_por_flag: assert property (@(posedge core_clk_i) // R10
		por_detect_i |-> !low_voltage_reset_enable_flag_o)
		else $error("flag kept through power-on");

	// The sync release must never run ahead of the request
	chk_sync_low: assert property (@(posedge core_clk_i) // R13
		arst_req |-> !srst_n)
		else $error("sync release during request");

	chk_osc_free: assert property (@(posedge core_clk_i) // R3
		!arst_req |-> osc_enable_o)
		else $error("oscillator stopped without request");

	chk_wait_held: assert property (@(posedge core_clk_i) // R5
		(state_r != PORDR_RUN) |-> !unit_reset_n_o)
		else $error("units released early");

	// Checks on the flag, gated off during power-on or rstn_i reset, and on the sequencer, gated off while any reset stands
	chk_flag_write: assert property (@(posedge core_clk_i)
		disable iff (por_detect_i || !rstn_i) // R6
		low_voltage_reset_enable_flag_wr_i |=>
		low_voltage_reset_enable_flag_o == $past(low_voltage_reset_enable_flag_i))
		else $error("flag write lost");

	chk_flag_keep: assert property (@(posedge core_clk_i)
		disable iff (por_detect_i || !rstn_i) // R6
		!low_voltage_reset_enable_flag_wr_i |=> $stable(low_voltage_reset_enable_flag_o))
		else $error("flag changed without write");

	chk_hold_exit: assert property (@(posedge core_clk_i)
		disable iff (arst_req || !rstn_i) // R9
		(state_r == PORDR_HOLD && srst_n) |=> state_r == PORDR_WAIT)
		else $error("hold did not start wait");

	// Once running, only a new reset request may stop execution
	chk_run_stay: assert property (@(posedge core_clk_i)
		disable iff (arst_req || !rstn_i) // R5
		run_o |=> run_o)
		else $error("run dropped without reset");

	cov_run: cover property (@(posedge core_clk_i) $rose(run_o));
	cov_lv: cover property (@(posedge core_clk_i) low_voltage_i && en_r);
	cov_por: cover property (@(posedge core_clk_i) $fell(por_detect_i));
	cov_flag_set: cover property (@(posedge core_clk_i) $rose(low_voltage_reset_enable_flag_o));
endmodule

//--- tb/pordr_seq_tb.sv
// Bench for the reset sequencer.
// Assumes a free-running bench clock; gating is only observed.
`timescale 1ns/10ps
module pordr_seq_tb;
	import pordr_pkg::*;
	logic clk, rstn, por, drop, fl, wr, por_d, lv, osc, urn, run, flo;
	logic [PORDR_PC_W-1:0] pc;
	int num_errors = 0;
	int compares = 0;
	pordr_supply_model sup (.por_req_i(por), .drop_req_i(drop), .por_detect_o(por_d),
		.low_voltage_o(lv));
	pordr_seq dut (.core_clk_i(clk), .rstn_i(rstn), .por_detect_i(por_d),
		.low_voltage_i(lv), .low_voltage_reset_enable_flag_i(fl),
		.low_voltage_reset_enable_flag_wr_i(wr), .osc_enable_o(osc),
		.unit_reset_n_o(urn), .run_o(run), .start_pc_o(pc),
		.low_voltage_reset_enable_flag_o(flo));
	task automatic chk(string what, logic [9:0] exp, logic [9:0] got);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic step(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic report_and_stop;
		if (num_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic t_power_on;
		int n = 0;
		por = 1'b1;
		step(6);
		chk("osc", 0, osc);
		chk("unit", 0, urn);
		rstn = 1'b1;
		por = 1'b0;
		step(1);
		chk("osc", 1, osc);
		// Bounded wait, a little past the full count
		while (run !== 1'b1 && n < 65600) begin
			step(1);
			n++;
		end
		chk("wait", 1, n >= 65536);
		chk("run", 1, run);
		chk("pc", 0, pc);
	endtask
	task automatic t_drop_off;
		drop = 1'b1;
		step(4);
		chk("run", 1, run);
		chk("osc", 1, osc);
		drop = 1'b0;
		step(2);
	endtask
	task automatic t_drop_on;
		fl = 1'b1;
		wr = 1'b1;
		step(1);
		wr = 1'b0;
		chk("flag", 1, flo);
		drop = 1'b1;
		#5;
		chk("osc", 0, osc);
		step(8);
		chk("unit", 0, urn);
		drop = 1'b0;
		step(100);
		chk("run", 0, run);
		chk("osc", 1, osc);
		chk("flag", 1, flo);
		por = 1'b1;
		step(2);
		chk("flag", 0, flo);
		chk("osc", 0, osc);
		por = 1'b0;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#800us;
		num_errors++;
		report_and_stop();
	end
	initial begin
		{rstn, por, drop, fl, wr} = 5'h00;
		t_power_on();
		t_drop_off();
		t_drop_on();
		report_and_stop();
	end
endmodule

//--- tb/pordr_supply_model.sv
// Supply detector model: power-on and low-voltage comparators.
// Assumes the bench sets supply state through the request inputs.
`timescale 1ns/10ps
module pordr_supply_model (
	input wire logic por_req_i,
	input wire logic drop_req_i,
	output wire logic por_detect_o,
	output wire logic low_voltage_o
);
	assign #3 por_detect_o = por_req_i;
	assign #3 low_voltage_o = drop_req_i;
endmodule
